// >>> verilog/csif_pkg.sv
// Purpose: Shared types and constants of the instruction-fetch block
// Assumes: Storage characters arrive as csif_char_s, one per access
// Notes:   Op-code values and length masks below are a small example set
package csif_pkg;

	// ------------------------------------------------------------------
	// Character and address carriers
	// ------------------------------------------------------------------
	// One storage position: delimiter flag plus seven code bits
	typedef struct packed {
		logic       wm;   // Word-delimiter flag (eighth plane)
		logic       chk;  // Odd-parity check bit
		logic       zb;   // Zone B
		logic       za;   // Zone A
		logic [3:0] num;  // Numeric weights 8-4-2-1
	} csif_char_s;

	// Storage address: five decimal digits, d4 is ten-thousands
	typedef struct packed {
		logic [3:0] d4;
		logic [3:0] d3;
		logic [3:0] d2;
		logic [3:0] d1;
		logic [3:0] d0;
	} csif_addr_s;

	// Address register: five positions of {zb, za, num}, [0] high order
	typedef logic [0:4][5:0] csif_areg_t;

	// Operation classes, each with its own set of legal lengths
	typedef enum logic [2:0] {
		CLS_BAD   = 3'h0,
		CLS_ONE   = 3'h1,
		CLS_MOD   = 3'h2,
		CLS_ARITH = 3'h3,
		CLS_MOVE  = 3'h4,
		CLS_IO    = 3'h5
	} csif_class_e;

	// ------------------------------------------------------------------
	// Constants
	// ------------------------------------------------------------------
	localparam int          RING_W      = 13;
	localparam int          STG_UNIT_END = 3;
	localparam int          STG_B_FIRST = 6;
	localparam int          STG_MOD     = 11;
	localparam int          STG_END     = 12;
	localparam logic [3:0]  BCD_ZERO    = 4'ha;
	localparam int          SIZE_UNIT   = 10000;
	localparam int          SIZE_MAX    = 80000;
	localparam csif_addr_s  RST_ADDR    = 20'h00000;

	// Example op codes as {zb, za, num}
	localparam logic [5:0]  OPC_ADD     = 6'h31;
	localparam logic [5:0]  OPC_MOVE    = 6'h24;
	localparam logic [5:0]  OPC_IO      = 6'h14;
	localparam logic [5:0]  OPC_BRMOD   = 6'h32;
	localparam logic [5:0]  OPC_HALT    = 6'h38;

	// Legal lengths as bit masks, bit n set means n characters allowed
	localparam logic [12:0] LEN_ONE     = 13'h0002;
	localparam logic [12:0] LEN_MOD     = 13'h0004;
	localparam logic [12:0] LEN_ARITH   = 13'h0842;
	localparam logic [12:0] LEN_MOVE    = 13'h1082;
	localparam logic [12:0] LEN_IO      = 13'h0420;

	// Error-stop codes
	localparam logic [2:0]  ERR_NONE    = 3'h0;
	localparam logic [2:0]  ERR_OPWM    = 3'h1;
	localparam logic [2:0]  ERR_OPCODE  = 3'h2;
	localparam logic [2:0]  ERR_DIGIT   = 3'h3;
	localparam logic [2:0]  ERR_ZONE    = 3'h4;
	localparam logic [2:0]  ERR_RANGE   = 3'h5;
	localparam logic [2:0]  ERR_LENGTH  = 3'h6;

endpackage

// >>> verilog/csif_fetch.sv
// Purpose: Instruction fetch and address check of a character-serial
//          decimal processor
// Assumes: One storage read outstanding; data answers some cycles later
// Notes:   Halts with an error code on any check failure until restarted
`timescale 1ns/1ps

module csif_fetch #(
	parameter int STORAGE_SIZE = csif_pkg::SIZE_MAX
) (
	input  wire logic                   i_clock,
	input  wire logic                   i_nrst,
	input  wire logic                   i_start,
	input  wire csif_pkg::csif_addr_s   i_start_addr,
	input  wire logic                   i_rd_valid,
	input  wire csif_pkg::csif_char_s   i_rd_char,
	input  wire logic                   i_exec_done,
	output logic                        o_rd_req,
	output csif_pkg::csif_addr_s        o_rd_addr,
	output logic                        o_exec_start,
	output logic                        o_fetching,
	output logic                        o_error_stop,
	output logic [2:0]                  o_err_code,
	output logic [6:0]                  o_op_register,
	output csif_pkg::csif_class_e       o_op_class,
	output logic [3:0]                  o_length,
	output logic                        o_scan_reverse,
	output csif_pkg::csif_areg_t        o_first_operand_address_register,
	output csif_pkg::csif_areg_t        o_second_operand_address_register,
	output logic [6:0]                  o_operation_modifier_register,
	output csif_pkg::csif_addr_s        o_next_addr
);
	import csif_pkg::*;

	// ------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------
	// Class of an op-code character; unknown codes are refused
	function automatic csif_class_e op_class(input csif_char_s c);
		logic [5:0] code;
		code = {c.zb, c.za, c.num};
		unique case (code)
			OPC_ADD:   op_class = CLS_ARITH;
			OPC_MOVE:  op_class = CLS_MOVE;
			OPC_IO:    op_class = CLS_IO;
			OPC_BRMOD: op_class = CLS_MOD;
			OPC_HALT:  op_class = CLS_ONE;
			default:   op_class = CLS_BAD;
		endcase
	endfunction

	// Legal lengths per class; no mask holds two adjacent bits
	function automatic logic [12:0] len_mask(input csif_class_e k);
		unique case (k)
			CLS_ONE:   len_mask = LEN_ONE;
			CLS_MOD:   len_mask = LEN_MOD;
			CLS_ARITH: len_mask = LEN_ARITH;
			CLS_MOVE:  len_mask = LEN_MOVE;
			CLS_IO:    len_mask = LEN_IO;
			default:   len_mask = 13'h0000;
		endcase
	endfunction

	// Decimal increment with carry through all five digits
	function automatic csif_addr_s addr_inc(input csif_addr_s a);
		logic [19:0] v;
		logic        cy;
		v  = a;
		cy = 1'b1;
		for (int i = 0; i < 5; i++)
		begin
			if (cy)
			begin
				if (v[i*4 +: 4] == 4'h9)
					v[i*4 +: 4] = 4'h0;
				else
				begin
					v[i*4 +: 4] = v[i*4 +: 4] + 4'h1;
					cy = 1'b0;
				end
			end
		end
		addr_inc = v;
	endfunction

	// ------------------------------------------------------------------
	// State and registers
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_REQ  = 3'b001,
		ST_WAIT = 3'b011,
		ST_EXEC = 3'b010,
		ST_HALT = 3'b110
	} csif_state_e;

	localparam logic [3:0] TT_LIMIT = 4'(STORAGE_SIZE / SIZE_UNIT);

	csif_state_e        state_r;
	csif_state_e        state_nxt;
	logic [RING_W-1:0]  ring_r;
	logic [RING_W-1:0]  ring_nxt;
	logic [3:0]         count_r;
	csif_addr_s         cur_addr_r;
	csif_class_e        cls_r;
	logic [6:0]         op_r;
	csif_areg_t         areg_r;
	csif_areg_t         breg_r;
	logic [6:0]         mod_r;
	logic               rd_req_r;
	logic               exec_start_r;
	logic [2:0]         err_r;
	logic               scan_rev_r;
	logic               fetching_r;
	logic               halt_r;

	// ------------------------------------------------------------------
	// Character decode
	// ------------------------------------------------------------------
	// Which ring stage holds the character now arriving
	wire         got        = (state_r == ST_WAIT) && i_rd_valid;
	wire         at_op      = ring_r[0];
	wire         at_end     = ring_r[STG_END];
	wire         in_a       = |ring_r[5:1];
	wire         in_b       = |ring_r[10:6];
	wire         in_mod     = ring_r[STG_MOD];
	wire csif_class_e cls_in = op_class(i_rd_char);

	// Unit field of an I/O op sits in the first register but is no address
	wire         chk_addr   = (in_a && (cls_r != CLS_IO)) || in_b;
	wire [4:0]   pos        = in_a ? ring_r[5:1] : ring_r[10:6];
	wire [3:0]   num        = i_rd_char.num;
	wire [3:0]   digit      = (num == BCD_ZERO) ? 4'h0 : num;
	wire         digit_bad  = (num == 4'h0) || (num > BCD_ZERO);
	wire         has_zone   = i_rd_char.za | i_rd_char.zb;
	wire         zone_bad   = has_zone && !(pos[2] | pos[3]);
	wire         range_bad  = pos[0] && (digit >= TT_LIMIT);
	wire         fetch_bad  = cur_addr_r.d4 >= TT_LIMIT;

	// Length read so far against the decoded op code
	wire [12:0]  legal      = len_mask(cls_r);
	wire         len_ok     = legal[count_r];

	// Error found on this character, in priority order
	logic [2:0]  err_nxt;
	always_comb
	begin
		err_nxt = ERR_NONE;
		if (at_op && !i_rd_char.wm)
			err_nxt = ERR_OPWM;
		else if (at_op && cls_in == CLS_BAD)
			err_nxt = ERR_OPCODE;
		else if (!at_op && i_rd_char.wm && !len_ok)
			err_nxt = ERR_LENGTH;
		else if (!at_op && !i_rd_char.wm && at_end)
			err_nxt = ERR_LENGTH;
		else if (!at_op && !i_rd_char.wm && chk_addr && digit_bad)
			err_nxt = ERR_DIGIT;
		else if (!at_op && !i_rd_char.wm && chk_addr && zone_bad)
			err_nxt = ERR_ZONE;
		else if (!at_op && !i_rd_char.wm && chk_addr && range_bad)
			err_nxt = ERR_RANGE;
	end

	// Flag on a later character marks the next op: the instruction ends
	wire         done_ok    = got && !at_op && i_rd_char.wm && len_ok;
	wire         take       = got && (err_nxt == ERR_NONE) && !done_ok;

	// ------------------------------------------------------------------
	// Ring advance
	// ------------------------------------------------------------------
	// Op-only modifier ops skip to the modifier stage; I/O unit field
	// skips the unused first-address positions
	always_comb
	begin
		ring_nxt = {ring_r[RING_W-2:0], 1'b0};
		if (at_op && cls_in == CLS_MOD)
			ring_nxt = 13'h0800;
		else if (ring_r[STG_UNIT_END] && cls_r == CLS_IO)
			ring_nxt = 13'h0040;
	end

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE,
			ST_HALT:
				if (i_start)
					state_nxt = ST_REQ;
			ST_REQ:
				state_nxt = fetch_bad ? ST_HALT : ST_WAIT;
			ST_WAIT:
				if (got)
				begin
					if (err_nxt != ERR_NONE)
						state_nxt = ST_HALT;
					else if (done_ok)
						state_nxt = ST_EXEC;
					else
						state_nxt = ST_REQ;
				end
			ST_EXEC:
				if (i_exec_done)
					state_nxt = ST_REQ;
		endcase
	end

	// State, ring, count and address pointer
	always_ff @(posedge i_clock)
	begin
		if (!i_nrst)
		begin
			state_r    <= ST_IDLE;
			ring_r     <= 13'h0001;
			count_r    <= 4'h0;
			cur_addr_r <= RST_ADDR;
		end
		else
		begin
			state_r <= state_nxt;
			if ((state_r == ST_IDLE || state_r == ST_HALT) && i_start)
				cur_addr_r <= i_start_addr;
			else if (take)
				cur_addr_r <= addr_inc(cur_addr_r);
			if (state_nxt == ST_REQ && state_r != ST_WAIT)
			begin
				ring_r  <= 13'h0001;
				count_r <= 4'h0;
			end
			else if (take)
			begin
				ring_r  <= ring_nxt;
				count_r <= count_r + 4'h1;
			end
		end
	end

	// Storage read strobe, one character per access
	always_ff @(posedge i_clock)
	begin
		if (!i_nrst)
			rd_req_r <= 1'b0;
		else
			rd_req_r <= (state_r == ST_REQ) && !fetch_bad;
	end

	// Execute start pulse and error-stop code
	always_ff @(posedge i_clock)
	begin
		if (!i_nrst)
		begin
			exec_start_r <= 1'b0;
			err_r        <= ERR_NONE;
		end
		else
		begin
			exec_start_r <= done_ok;
			if ((state_r == ST_IDLE || state_r == ST_HALT) && i_start)
				err_r <= ERR_NONE;
			else if (state_r == ST_REQ && fetch_bad)
				err_r <= ERR_RANGE;
			else if (got && err_nxt != ERR_NONE)
				err_r <= err_nxt;
		end
	end

	// Phase flags from the next state, so the ports carry no decode
	always_ff @(posedge i_clock)
	begin
		if (!i_nrst)
		begin
			fetching_r <= 1'b0;
			halt_r     <= 1'b0;
		end
		else
		begin
			fetching_r <= (state_nxt == ST_REQ) || (state_nxt == ST_WAIT);
			halt_r     <= (state_nxt == ST_HALT);
		end
	end

	// ------------------------------------------------------------------
	// Field registers
	// ------------------------------------------------------------------
	// Gate each accepted character to its register by ring stage;
	// a new op clears the operand registers so stale digits never show
	always_ff @(posedge i_clock)
	begin
		if (!i_nrst)
		begin
			op_r       <= 7'h00;
			cls_r      <= CLS_BAD;
			scan_rev_r <= 1'b0;
			areg_r     <= '0;
			breg_r     <= '0;
			mod_r      <= 7'h00;
		end
		else if (take && at_op)
		begin
			op_r       <= i_rd_char[6:0];
			cls_r      <= cls_in;
			scan_rev_r <= (cls_in == CLS_MOVE) || (cls_in == CLS_IO);
			areg_r     <= '0;
			breg_r     <= '0;
			mod_r      <= 7'h00;
		end
		else if (take)
		begin
			for (int k = 0; k < 5; k++)
			begin
				if (ring_r[k+1])
					areg_r[k] <= i_rd_char[5:0];
				if (ring_r[k+STG_B_FIRST])
					breg_r[k] <= i_rd_char[5:0];
			end
			if (in_mod)
				mod_r <= i_rd_char[6:0];
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign o_rd_req                          = rd_req_r;
	assign o_rd_addr                         = cur_addr_r;
	assign o_exec_start                      = exec_start_r;
	assign o_fetching                        = fetching_r;
	assign o_error_stop                      = halt_r;
	assign o_err_code                        = err_r;
	assign o_op_register                     = op_r;
	assign o_op_class                        = cls_r;
	assign o_length                          = count_r;
	assign o_scan_reverse                    = scan_rev_r;
	assign o_first_operand_address_register  = areg_r;
	assign o_second_operand_address_register = breg_r;
	assign o_operation_modifier_register     = mod_r;
	assign o_next_addr                       = cur_addr_r;

endmodule

// >>> tb/csif_store_model.sv
// Purpose: Character storage seen by the fetch block
// Assumes: Bench fills mem before starting a fetch
// Notes:   Idle data lines show the inverse of the last character
`timescale 1ns/1ps
module csif_store_model (
	input  wire logic                 i_clock,
	input  wire logic                 i_req,
	input  wire csif_pkg::csif_addr_s i_addr,
	input  wire logic [3:0]           i_dly,
	output logic                      o_valid = 1'b0,
	output csif_pkg::csif_char_s      o_char = '0
);
	import csif_pkg::*;
	csif_char_s mem [int];
	csif_char_s last = '0;
	csif_char_s rd;
	logic [3:0] cnt = 4'h0;
	int         a;
	// --------------------------------------------------------------
	// Read answer after i_dly cycles, one character per request
	// --------------------------------------------------------------
	always @(negedge i_clock)
	begin
		a = i_addr.d4 * 10000 + i_addr.d3 * 1000 + i_addr.d2 * 100;
		a = a + i_addr.d1 * 10 + i_addr.d0;
		rd = mem.exists(a) ? mem[a] : '0;
		o_valid <= 1'b0;
		o_char <= ~last;
		if (cnt == 4'h1)
		begin
			o_valid <= 1'b1;
			o_char <= rd;
			last <= rd;
		end
		if (cnt != 4'h0)
			cnt <= cnt - 4'h1;
		if (i_req)
			cnt <= i_dly;
	end
endmodule

// >>> tb/csif_fetch_monitor.sv
// Purpose: Port assertions for the fetch block
// Assumes: One storage read outstanding
// Notes:   nchar_r counts characters taken in this instruction
`timescale 1ns/1ps
module csif_fetch_monitor #(
	parameter int STORAGE_SIZE = csif_pkg::SIZE_MAX
) (
	input wire logic                  i_clock,
	input wire logic                  i_nrst,
	input wire logic                  i_start,
	input wire csif_pkg::csif_addr_s  i_start_addr,
	input wire logic                  i_rd_valid,
	input wire csif_pkg::csif_char_s  i_rd_char,
	input wire logic                  i_exec_done,
	input wire logic                  o_rd_req,
	input wire csif_pkg::csif_addr_s  o_rd_addr,
	input wire logic                  o_exec_start,
	input wire logic                  o_fetching,
	input wire logic                  o_error_stop,
	input wire logic [2:0]            o_err_code,
	input wire csif_pkg::csif_class_e o_op_class,
	input wire logic [3:0]            o_length
);
	import csif_pkg::*;
	localparam int LIM = STORAGE_SIZE / 10000;
	logic        in_exec_r;
	logic [3:0]  nchar_r;
	logic        take;
	logic        go;
	logic        dig_ok;
	logic        len_ok;
	logic [12:0] mask;
	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	assign take = o_fetching && i_rd_valid;
	assign go = i_start && !o_fetching && !in_exec_r;
	assign dig_ok = i_rd_char.num inside {[4'h1:4'ha]};
	assign mask = (o_op_class == CLS_ARITH) ? LEN_ARITH :
		(o_op_class == CLS_MOVE) ? LEN_MOVE :
		(o_op_class == CLS_IO) ? LEN_IO :
		(o_op_class == CLS_MOD) ? LEN_MOD :
		(o_op_class == CLS_ONE) ? LEN_ONE : 13'h0;
	assign len_ok = (o_length < 4'hd) && mask[o_length];
	// Index restarts on each new fetch, so a halted run cannot leak
	always_ff @(posedge i_clock)
	begin
		if (!i_nrst || i_start || o_exec_start)
			nchar_r <= 4'h0;
		else if (take)
			nchar_r <= nchar_r + 4'h1;
	end
	always_ff @(posedge i_clock)
	begin
		if (!i_nrst || i_exec_done)
			in_exec_r <= 1'b0;
		else if (o_exec_start)
			in_exec_r <= 1'b1;
	end
	function automatic int ai(csif_addr_s x);
		return x.d4 * 10000 + x.d3 * 1000 + x.d2 * 100 + x.d1 * 10 + x.d0;
	endfunction
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_nrst);
	sequence s_step;
		take ##2 o_rd_req;
	endsequence
	property p_start;
		go && i_start_addr.d4 < LIM
			|-> ##2 o_rd_req && o_rd_addr == $past(i_start_addr, 2);
	endproperty
	a_start: assert property (p_start)
		else $error("first read missing");
	property p_range;
		go && i_start_addr.d4 >= LIM
			|=> ##[0:2] o_error_stop && o_err_code == ERR_RANGE;
	endproperty
	a_range: assert property (p_range)
		else $error("range stop missing");
	property p_step;
		s_step |-> ai(o_rd_addr) == ai($past(o_rd_addr, 2)) + 1;
	endproperty
	a_step: assert property (p_step)
		else $error("read address not sequential");
	property p_op_wm;
		take && nchar_r == 4'h0 && !i_rd_char.wm
			|=> o_error_stop && o_err_code == ERR_OPWM;
	endproperty
	a_op_wm: assert property (p_op_wm)
		else $error("op flag stop missing");
	property p_end_ok;
		take && nchar_r != 4'h0 && i_rd_char.wm && len_ok |=> o_exec_start;
	endproperty
	a_end_ok: assert property (p_end_ok)
		else $error("execute start missing");
	property p_len_bad;
		take && nchar_r != 4'h0 && i_rd_char.wm && !len_ok
			|=> o_error_stop && o_err_code == ERR_LENGTH;
	endproperty
	a_len_bad: assert property (p_len_bad)
		else $error("length stop missing");
	property p_digit;
		take && nchar_r == 4'h1 && o_op_class == CLS_ARITH
			&& !i_rd_char.wm && !dig_ok
			|=> o_error_stop && o_err_code == ERR_DIGIT;
	endproperty
	a_digit: assert property (p_digit)
		else $error("digit stop missing");
	property p_zone;
		take && nchar_r == 4'h5 && o_op_class == CLS_ARITH && !i_rd_char.wm
			&& dig_ok && (i_rd_char.zb || i_rd_char.za)
			|=> o_error_stop && o_err_code == ERR_ZONE;
	endproperty
	a_zone: assert property (p_zone)
		else $error("zone stop missing");
endmodule
bind csif_fetch csif_fetch_monitor #(.STORAGE_SIZE(STORAGE_SIZE)) u_mon (
	.i_clock(i_clock), .i_nrst(i_nrst), .i_start(i_start),
	.i_start_addr(i_start_addr), .i_rd_valid(i_rd_valid),
	.i_rd_char(i_rd_char), .i_exec_done(i_exec_done),
	.o_rd_req(o_rd_req), .o_rd_addr(o_rd_addr),
	.o_exec_start(o_exec_start), .o_fetching(o_fetching),
	.o_error_stop(o_error_stop), .o_err_code(o_err_code),
	.o_op_class(o_op_class), .o_length(o_length));

// >>> tb/tb_char_serial_instruction_fetch.sv
// Purpose: Self-checking bench for the fetch block
// Assumes: Storage capacity set to two units to reach the range stop
// Notes:   Each fetch scenario resets the block first
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
	num_errors++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb_char_serial_instruction_fetch;
	import csif_pkg::*;
	logic clock, nrst, start, rd_valid, exec_done, rd_req, exec_start;
	logic fetching, error_stop, scan_rev;
	logic [2:0] err_code;
	logic [3:0] dly, length;
	logic [6:0] op_reg, mod_reg;
	csif_addr_s start_addr, rd_addr, next_addr;
	csif_char_s rd_char;
	csif_class_e op_class;
	csif_areg_t areg, breg;
	int num_errors = 0;
	int cmp_count = 0;
	int wp = 0;
	int cycles = 0;
	// --------------------------------------------------------------
	// Block, storage and clock
	// --------------------------------------------------------------
	csif_fetch #(.STORAGE_SIZE(20000)) dut (.i_clock(clock), .i_nrst(nrst),
		.i_start(start), .i_start_addr(start_addr), .i_rd_valid(rd_valid),
		.i_rd_char(rd_char), .i_exec_done(exec_done), .o_rd_req(rd_req),
		.o_rd_addr(rd_addr), .o_exec_start(exec_start),
		.o_fetching(fetching), .o_error_stop(error_stop),
		.o_err_code(err_code), .o_op_register(op_reg),
		.o_op_class(op_class), .o_length(length), .o_scan_reverse(scan_rev),
		.o_first_operand_address_register(areg),
		.o_second_operand_address_register(breg),
		.o_operation_modifier_register(mod_reg), .o_next_addr(next_addr));
	csif_store_model stor (.i_clock(clock), .i_req(rd_req),
		.i_addr(rd_addr), .i_dly(dly), .o_valid(rd_valid), .o_char(rd_char));
	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	// Hang guard, far above the longest scenario
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("Compares %0d, errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	function automatic csif_char_s dg(int d);
		return {4'h0, (d == 0) ? 4'ha : 4'(d)};
	endfunction
	function automatic csif_char_s op(logic [5:0] c);
		return {2'b10, c};
	endfunction
	function automatic csif_addr_s ad(int v);
		return {4'(v / 10000), 4'(v / 1000 % 10), 4'(v / 100 % 10),
			4'(v / 10 % 10), 4'(v % 10)};
	endfunction
	task automatic put(csif_char_s c);
		stor.mem[wp] = c;
		wp++;
	endtask
	// Five address characters, high order first
	task automatic pa(int v);
		for (int i = 10000; i > 0; i /= 10)
			put(dg(v / i % 10));
	endtask
	task automatic wait_end(logic [2:0] e);
		int n;
		n = 0;
		while (exec_start !== 1'b1 && error_stop !== 1'b1 && n < 300)
		begin
			@(negedge clock);
			n++;
		end
		`CHK("err_code", e, err_code)
		`CHK("exec_start", e == ERR_NONE, exec_start)
		`CHK("stop", e != ERR_NONE, error_stop)
		`CHK("fetching", 1'b0, fetching)
	endtask
	task automatic fetch(int a, logic [2:0] e);
		nrst = 1'b0;
		repeat (2) @(negedge clock);
		nrst = 1'b1;
		start = 1'b1;
		start_addr = ad(a);
		@(negedge clock);
		start = 1'b0;
		wait_end(e);
	endtask
	task automatic next_instr(logic [2:0] e);
		exec_done = 1'b1;
		@(negedge clock);
		exec_done = 1'b0;
		wait_end(e);
	endtask
	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	// Longest add at the top address, index tag on tens, then a chain
	task automatic t_add();
		wp = 100;
		put(op(OPC_ADD));
		pa(19999);
		pa(567);
		put(op(OPC_HALT));
		put(op(OPC_HALT));
		stor.mem[104] = 8'h19;
		fetch(100, ERR_NONE);
		`CHK("len", 4'hb, length)
		`CHK("op", 7'h31, op_reg)
		`CHK("areg", csif_areg_t'({6'h01, 6'h09, 6'h09, 6'h19, 6'h09}), areg)
		`CHK("breg", csif_areg_t'({6'h0a, 6'h0a, 6'h05, 6'h06, 6'h07}), breg)
		`CHK("scan", 1'b0, scan_rev)
		`CHK("next", ad(111), next_addr)
		next_instr(ERR_NONE);
		`CHK("class", CLS_ONE, op_class)
		`CHK("next1", ad(112), next_addr)
	endtask
	// Full twelve characters with a slow storage
	task automatic t_move();
		dly = 4'h4;
		wp = 200;
		put(op(OPC_MOVE));
		pa(300);
		pa(400);
		put(8'h27);
		put(op(OPC_HALT));
		fetch(200, ERR_NONE);
		`CHK("len", 4'hc, length)
		`CHK("mod", 7'h27, mod_reg)
		`CHK("scan", 1'b1, scan_rev)
		dly = 4'h1;
	endtask
	// Unit field with second address, then an op with modifier only
	task automatic t_io();
		wp = 600;
		put(op(OPC_IO));
		put(dg(1));
		put(8'h24);
		put(dg(2));
		pa(1234);
		put(8'h21);
		put(op(OPC_BRMOD));
		put(8'h35);
		put(op(OPC_HALT));
		fetch(600, ERR_NONE);
		`CHK("unit", {6'h01, 6'h24, 6'h02}, areg[0:2])
		`CHK("breg", csif_areg_t'({6'h0a, 6'h01, 6'h02, 6'h03, 6'h04}), breg)
		`CHK("scan", 1'b1, scan_rev)
		next_instr(ERR_NONE);
		`CHK("mod", 7'h35, mod_reg)
		`CHK("len", 4'h2, length)
	endtask
	// Add with one disturbed character; flag placed after n characters
	task automatic t_bad(csif_char_s c0, csif_char_s c1, csif_char_s c5,
		int n, logic [2:0] e);
		csif_char_s p [7] = '{c0, c1, dg(2), dg(3), dg(4), c5, dg(0)};
		wp = 500;
		foreach (p[i])
			put(p[i]);
		stor.mem[500 + n] = op(OPC_HALT);
		fetch(500, e);
	endtask
	initial
	begin
		nrst = 1'b0;
		start = 1'b0;
		start_addr = RST_ADDR;
		exec_done = 1'b0;
		dly = 4'h1;
		repeat (5) @(negedge clock);
		`CHK("rst_class", CLS_BAD, op_class)
		`CHK("rst_err", ERR_NONE, err_code)
		`CHK("rst_stop", 1'b0, error_stop)
		t_add();
		t_move();
		t_io();
		t_bad(op(OPC_ADD) & 8'h7f, dg(1), dg(5), 6, ERR_OPWM);
		t_bad(op(6'h3f), dg(1), dg(5), 6, ERR_OPCODE);
		t_bad(op(OPC_ADD), dg(1), dg(5), 5, ERR_LENGTH);
		t_bad(op(OPC_ADD), 8'h00, dg(5), 6, ERR_DIGIT);
		t_bad(op(OPC_ADD), 8'h0b, dg(5), 6, ERR_DIGIT);
		t_bad(op(OPC_ADD), dg(1), 8'h15, 6, ERR_ZONE);
		t_bad(op(OPC_ADD), dg(3), dg(5), 6, ERR_RANGE);
		fetch(30000, ERR_RANGE);
		complete_run();
	end
endmodule
